// *** hdl/wlp_pkg.sv ***
package wlp_pkg;

    // Register byte offsets on the plain register port
    localparam logic [7:0] WLP_OFS_WDCTRL   = 8'h00;
    localparam logic [7:0] WLP_OFS_WDKEY    = 8'h04;
    localparam logic [7:0] WLP_OFS_WDCOUNT  = 8'h08;
    localparam logic [7:0] WLP_OFS_SLEEPCTL = 8'h0C;
    localparam logic [7:0] WLP_OFS_WAKESEL  = 8'h10;
    localparam logic [7:0] WLP_OFS_IRQSTAT  = 8'h14;
    localparam logic [7:0] WLP_OFS_IRQCLR   = 8'h18;
    localparam logic [7:0] WLP_OFS_IRQEN    = 8'h1C;
    localparam logic [7:0] WLP_OFS_STATE    = 8'h20;

    // Watchdog control fields
    localparam int WLP_WDCTRL_DIS     = 0;
    localparam int WLP_WDCTRL_IRQMODE = 1;
    localparam int WLP_WDCTRL_WAKEEN  = 2;

    // Sleep control fields: mode in [1:0], qualify count in [7:2]
    localparam int WLP_SLP_MODE_LSB = 0;
    localparam int WLP_SLP_QUAL_LSB = 2;
    localparam int WLP_QUAL_W       = 6;

    // Interrupt status bits
    localparam int WLP_IRQ_W     = 3;
    localparam int WLP_IRQ_WDOVF = 0;
    localparam int WLP_IRQ_WAKE  = 1;
    localparam int WLP_IRQ_KEYER = 2;

    localparam logic [7:0]  WLP_KEY_FIRST  = 8'h55;
    localparam logic [7:0]  WLP_KEY_SECOND = 8'hAA;
    localparam logic [7:0]  WLP_WD_MAX     = 8'hFF;
    localparam logic [2:0]  WLP_WDCTRL_RST = 3'h0;
    localparam logic [7:0]  WLP_SLEEP_RST  = 8'h00;

    // Reset pulse width in oscillator clocks
    localparam int          WLP_WATCHDOG_RESET_OUT_CYC   = 512;
    localparam logic [9:0]  WLP_WATCHDOG_RESET_OUT_LEN   = 10'(WLP_WATCHDOG_RESET_OUT_CYC);
    // Exit signal must stay low this long to be recognised
    localparam int          WLP_RECOG_NS    = 32;
    localparam int          WLP_CLK_NS      = 8;
    localparam logic [3:0]  WLP_RECOG_CYC   =
        4'((WLP_RECOG_NS + WLP_CLK_NS - 1) / WLP_CLK_NS);

    localparam logic [1:0]  WLP_MODE_IDLE    = 2'h0;
    localparam logic [1:0]  WLP_MODE_STANDBY = 2'h1;

    typedef enum logic [2:0] {
        ST_RUN, ST_IDLE, ST_STANDBY, ST_HALT, ST_WAKE
    } wlp_state_t;

    // Clock enables handed to the clock tree
    typedef struct packed {
        logic osc;
        logic pll;
        logic cpu;
        logic sysOut;
    } wlp_clk_t;

    // Active-low exit sources
    typedef struct packed {
        logic extResetN;
        logic nmiN;
        logic debugN;
        logic irqN;
    } wlp_exit_t;

endpackage

// *** hdl/wlp_watchdog_sleep.sv ***
// Summary of operation
// - Counter at maximum drives watchdog reset (in interrupt mode the wake interrupt) low for 512 oscillator clocks.
// - Counter clears when key 0x55 is followed by key 0xAA, or while external reset is low.
// - A disable bit stops the counter; no overflow pulse while disabled.
// - Watchdog runs on oscillator clock and keeps running in STANDBY.
// - Watchdog interrupt wakes from STANDBY when its wake enable is set.
// - In IDLE the watchdog interrupt reaches the CPU and ends idle.
// - In HALT the watchdog neither counts, wakes nor resets.
// - IDLE keeps all clocks; any interrupt, NMI, watchdog or reset exits.
// - STANDBY stops CPU and clock out; selected exits wake the device.
// - HALT stops all clocks but the test port clock; reset, wake pin, NMI or debugger exit.
// - In STANDBY a wake pin must stay low for two clocks more than the programmed count.
// - Exits are active low; all but external reset must persist, else the mode resumes.
// - Output pins hold their entry levels throughout any low-power mode.
// - The test port clock keeps running while the CPU clock is stopped.
`timescale 1ns/1ns
module wlp_watchdog_sleep (
    input  wire logic                mclk,
    input  wire logic                rstn,
    input  wire logic [7:0]          addr,
    input  wire logic [31:0]         wrData,
    input  wire logic                wrEn,
    input  wire logic                rdEn,
    output logic      [31:0]         rdData,
    input  wire logic                idleExec,
    input  wire wlp_pkg::wlp_exit_t  exitPins,
    input  wire logic [31:0]         gpioA,
    input  wire logic [31:0]         pinsIn,
    output logic      [31:0]         pinsOut,
    output wlp_pkg::wlp_clk_t        clkEn,
    output logic                     jtagClkEn,
    output logic                     watchdogResetOutN,
    output logic                     watchdogWakeIrqN,
    output logic                     irq
);
    import wlp_pkg::*;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    logic [2:0]           wdCtrl_q;
    logic [7:0]           sleepCtrl_q;
    logic [31:0]          wakeSel_q;
    logic [WLP_IRQ_W-1:0] irqStat_q;
    logic [WLP_IRQ_W-1:0] irqEn_q;
    logic [7:0]           wdCnt_q;
    logic                 keyArmed_q;
    logic [9:0]           pulseCnt_q;
    logic                 wdRstN_q;
    logic                 wdIrqN_q;
    logic [31:0]          rdData_q;
    logic                 irq_q;
    logic [31:0]          pins_q;
    wlp_clk_t             clk_q;
    wlp_state_t           state_q;
    wlp_state_t           resume_q;
    logic [WLP_QUAL_W:0]  qualCnt_q;
    logic [3:0]           recogCnt_q;
    logic                 jtagOn_q;

    logic                 wrKey;
    logic                 keyClear;
    logic                 wdRun;
    logic                 wdOverflow;
    logic                 keyError;
    logic                 wakeDone;
    logic                 pinLow;
    logic                 exitLow;
    logic                 wdWake;
    logic [WLP_IRQ_W-1:0] irqSet;
    logic [WLP_IRQ_W-1:0] irqClr;

    assign rdData            = rdData_q;
    assign pinsOut           = pins_q;
    assign clkEn             = clk_q;
    assign jtagClkEn         = jtagOn_q;
    assign watchdogResetOutN = wdRstN_q;
    assign watchdogWakeIrqN  = wdIrqN_q;
    assign irq               = irq_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            jtagOn_q <= 1'b0;
        end else begin
            jtagOn_q <= 1'b1;
        end
    end

    // Register writes
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wdCtrl_q    <= WLP_WDCTRL_RST;
            sleepCtrl_q <= WLP_SLEEP_RST;
            wakeSel_q   <= '0;
            irqEn_q     <= '0;
        end else if (wrEn) begin
            case (addr)
                WLP_OFS_WDCTRL:   wdCtrl_q    <= wrData[2:0];
                WLP_OFS_SLEEPCTL: sleepCtrl_q <= wrData[7:0];
                WLP_OFS_WAKESEL:  wakeSel_q   <= wrData;
                WLP_OFS_IRQEN:    irqEn_q     <= wrData[WLP_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Key sequence: a wrong value drops the armed state
    assign wrKey    = wrEn && (addr == WLP_OFS_WDKEY);
    assign keyClear = wrKey && keyArmed_q
                      && (wrData[7:0] == WLP_KEY_SECOND);
    assign keyError = wrKey && (wrData[7:0] != WLP_KEY_FIRST)
                      && !keyClear;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            keyArmed_q <= 1'b0;
        end else if (wrKey) begin
            keyArmed_q <= (wrData[7:0] == WLP_KEY_FIRST);
        end
    end

    // Oscillator is off in HALT, so the counter freezes there
    assign wdRun = !wdCtrl_q[WLP_WDCTRL_DIS]
                   && (state_q != ST_HALT)
                   && (pulseCnt_q == '0);
    assign wdOverflow = wdRun && (wdCnt_q == WLP_WD_MAX);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wdCnt_q <= '0;
        end else if (keyClear || !exitPins.extResetN) begin
            wdCnt_q <= '0;
        end else if (wdRun) begin
            wdCnt_q <= wdCnt_q + 8'h01;
        end
    end

    // Pulse of fixed width; output selects reset or interrupt
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pulseCnt_q <= '0;
            wdRstN_q   <= 1'b1;
            wdIrqN_q   <= 1'b1;
        end else if (wdOverflow) begin
            pulseCnt_q <= WLP_WATCHDOG_RESET_OUT_LEN;
            wdRstN_q   <= wdCtrl_q[WLP_WDCTRL_IRQMODE];
            wdIrqN_q   <= !wdCtrl_q[WLP_WDCTRL_IRQMODE];
        end else if (pulseCnt_q > 10'h001) begin
            pulseCnt_q <= pulseCnt_q - 10'h001;
        end else begin
            pulseCnt_q <= '0;
            wdRstN_q   <= 1'b1;
            wdIrqN_q   <= 1'b1;
        end
    end

    // Exit sources per mode
    assign pinLow = |(wakeSel_q & ~gpioA);
    assign wdWake = !wdIrqN_q && wdCtrl_q[WLP_WDCTRL_WAKEEN];
    always_comb begin
        case (resume_q)
            ST_IDLE:    exitLow = !exitPins.extResetN || !exitPins.nmiN
                                  || !exitPins.irqN || !wdIrqN_q;
            ST_STANDBY: exitLow = !exitPins.extResetN || !exitPins.nmiN
                                  || !exitPins.debugN || wdWake
                                  || (pinLow && qualCnt_q == '0);
            ST_HALT:    exitLow = !exitPins.extResetN || !exitPins.nmiN
                                  || !exitPins.debugN || pinLow;
            default:    exitLow = 1'b0;
        endcase
    end

    // Pin qualification runs only in STANDBY
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            qualCnt_q <= '0;
        end else if (pinLow && (state_q == ST_STANDBY
                     || (state_q == ST_WAKE && resume_q == ST_STANDBY))) begin
            // Held at zero through WAKE so the qualified exit stays valid
            if (qualCnt_q != '0) begin
                qualCnt_q <= qualCnt_q - 1'b1;
            end
        end else begin
            qualCnt_q <= {1'b0, sleepCtrl_q[WLP_SLP_QUAL_LSB +: WLP_QUAL_W]}
                         + 7'h01;
        end
    end

    assign wakeDone = (state_q == ST_WAKE)
                      && (recogCnt_q == WLP_RECOG_CYC);

    // Mode sequencer
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= ST_RUN;
            resume_q   <= ST_RUN;
            recogCnt_q <= '0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    recogCnt_q <= '0;
                    if (idleExec) begin
                        case (sleepCtrl_q[WLP_SLP_MODE_LSB +: 2])
                            WLP_MODE_IDLE: begin
                                state_q  <= ST_IDLE;
                                resume_q <= ST_IDLE;
                            end
                            WLP_MODE_STANDBY: begin
                                state_q  <= ST_STANDBY;
                                resume_q <= ST_STANDBY;
                            end
                            default: begin
                                state_q  <= ST_HALT;
                                resume_q <= ST_HALT;
                            end
                        endcase
                    end
                end
                ST_IDLE, ST_STANDBY, ST_HALT: begin
                    recogCnt_q <= '0;
                    if (!exitPins.extResetN) begin
                        state_q <= ST_RUN;
                    end else if (exitLow) begin
                        state_q <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (!exitPins.extResetN || wakeDone) begin
                        state_q <= ST_RUN;
                    end else if (!exitLow) begin
                        state_q <= resume_q;
                    end else begin
                        recogCnt_q <= recogCnt_q + 4'h1;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // Clock enables and pin holding
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            clk_q <= '{osc: 1'b1, pll: 1'b1, cpu: 1'b1, sysOut: 1'b1};
        end else begin
            case (state_q)
                ST_STANDBY: clk_q <= '{osc: 1'b1, pll: 1'b1,
                                       cpu: 1'b0, sysOut: 1'b0};
                ST_HALT:    clk_q <= '{osc: 1'b0, pll: 1'b0,
                                       cpu: 1'b0, sysOut: 1'b0};
                default:    clk_q <= '{osc: 1'b1, pll: 1'b1,
                                       cpu: 1'b1, sysOut: 1'b1};
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pins_q <= '0;
        end else if (state_q == ST_RUN && !idleExec) begin
            pins_q <= pinsIn;
        end
    end

    // Sticky status; a set in the clearing cycle wins
    assign irqSet = {keyError, wakeDone, wdOverflow};
    assign irqClr = (wrEn && addr == WLP_OFS_IRQCLR)
                    ? wrData[WLP_IRQ_W-1:0] : '0;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irqStat_q <= '0;
            irq_q     <= 1'b0;
        end else begin
            irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
            irq_q     <= |(((irqStat_q & ~irqClr) | irqSet) & irqEn_q);
        end
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdData_q <= '0;
        end else if (rdEn) begin
            case (addr)
                WLP_OFS_WDCTRL:   rdData_q <= {29'h0, wdCtrl_q};
                WLP_OFS_WDCOUNT:  rdData_q <= {24'h0, wdCnt_q};
                WLP_OFS_SLEEPCTL: rdData_q <= {24'h0, sleepCtrl_q};
                WLP_OFS_WAKESEL:  rdData_q <= wakeSel_q;
                WLP_OFS_IRQSTAT:  rdData_q <= {29'h0, irqStat_q};
                WLP_OFS_IRQEN:    rdData_q <= {29'h0, irqEn_q};
                WLP_OFS_STATE:    rdData_q <= {29'h0, state_q};
                default:          rdData_q <= '0;
            endcase
        end else begin
            rdData_q <= '0;
        end
    end

    // Helper: length of the current low pulse
    logic [10:0] lowLen_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lowLen_q <= '0;
        end else if (!wdRstN_q) begin
            lowLen_q <= lowLen_q + 11'h001;
        end else begin
            lowLen_q <= '0;
        end
    end

    sequence seqKeyPair;
        wrKey && wrData[7:0] == WLP_KEY_FIRST
        ##1 wrKey && wrData[7:0] == WLP_KEY_SECOND;
    endsequence

    sequence seqEnterIdle;
        state_q == ST_RUN && idleExec
        && sleepCtrl_q[1:0] == WLP_MODE_IDLE;
    endsequence

    // The counter already holds the full width when the output rises
    AST_WD_PULSE_LEN: assert property (
        $rose(wdRstN_q) |-> lowLen_q == 11'(WLP_WATCHDOG_RESET_OUT_CYC))
        else $error("watchdog reset pulse width wrong");
    AST_WD_OVF_PULSE: assert property (
        wdOverflow && !wdCtrl_q[WLP_WDCTRL_IRQMODE] |=> !wdRstN_q [*8])
        else $error("overflow did not start reset pulse");
    AST_KEY_CLEAR: assert property (
        seqKeyPair |=> wdCnt_q == 8'h00)
        else $error("key pair did not clear counter");
    AST_WD_DISABLED: assert property (
        wdCtrl_q[WLP_WDCTRL_DIS] |=> !$fell(wdRstN_q) && !$fell(wdIrqN_q))
        else $error("pulse while watchdog disabled");
    AST_HALT_FROZEN: assert property (
        state_q == ST_HALT && exitPins.extResetN && !keyClear
        |=> $stable(wdCnt_q))
        else $error("watchdog moved in halt");
    AST_IDLE_ENTRY: assert property (
        seqEnterIdle |=> state_q == ST_IDLE ##1 clk_q.cpu)
        else $error("idle entry wrong");
    AST_STANDBY_CLK: assert property (
        state_q == ST_STANDBY |=> clk_q.osc && !clk_q.cpu && !clk_q.sysOut)
        else $error("standby clocks wrong");
    AST_HALT_CLK: assert property (
        state_q == ST_HALT |=> !clk_q.osc && !clk_q.pll && !clk_q.cpu)
        else $error("halt clocks wrong");
    AST_PIN_HOLD: assert property (
        state_q != ST_RUN |=> $stable(pins_q))
        else $error("pins changed in low power");
    AST_RESUME: assert property (
        state_q == ST_WAKE && !exitLow && !wakeDone && exitPins.extResetN
        |=> state_q == $past(resume_q))
        else $error("short exit did not resume mode");
    AST_JTAG: assert property (
        state_q != ST_RUN |-> jtagClkEn)
        else $error("test port clock stopped");

endmodule

// *** bench/wlp_core_model.sv ***
`timescale 1ns/1ns
module wlp_core_model (
    input  wire logic          mclk,
    output logic               idleExec,
    output wlp_pkg::wlp_exit_t exitPins,
    output logic [31:0]        gpioA
);
    import wlp_pkg::*;

    // Exit lines and port A idle high, as if pulled up
    initial begin
        idleExec = 1'b0;
        exitPins = '1;
        gpioA    = '1;
    end

    // One-cycle idle instruction; the mode field is meant for this moment
    task automatic doIdle();
        @(posedge mclk) idleExec <= 1'b1;
        @(posedge mclk) idleExec <= 1'b0;
    endtask

    // Low time decides whether the device recognises the exit
    task automatic lowExit(input int idx, input int n);
        @(posedge mclk) exitPins[idx] <= 1'b0;
        repeat (n) @(posedge mclk);
        exitPins[idx] <= 1'b1;
    endtask

    task automatic lowPin(input int b, input int n);
        @(posedge mclk) gpioA[b] <= 1'b0;
        repeat (n) @(posedge mclk);
        gpioA[b] <= 1'b1;
    endtask
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import wlp_pkg::*;

    logic        mclk   = 1'b0;
    logic        rstn   = 1'b0;
    logic        wrEn   = 1'b0;
    logic        rdEn   = 1'b0;
    logic [7:0]  addr   = 8'h00;
    logic [31:0] wrData = 32'h0;
    logic [31:0] pinsIn = 32'h0;
    logic [31:0] rdData;
    logic [31:0] pinsOut;
    logic [31:0] gpioA;
    logic [31:0] rd;
    logic [31:0] c1;
    logic        idleExec;
    logic        jtagClkEn;
    logic        wdRstN;
    logic        wdIrqN;
    logic        irq;
    logic        lowSeen;
    wlp_exit_t   exitPins;
    wlp_clk_t    clkEn;
    int          miscompares = 0;
    int          checks_done = 0;

    always #4 mclk = ~mclk;

    wlp_watchdog_sleep DUT (
        .mclk(mclk), .rstn(rstn), .addr(addr), .wrData(wrData),
        .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .idleExec(idleExec),
        .exitPins(exitPins), .gpioA(gpioA), .pinsIn(pinsIn),
        .pinsOut(pinsOut), .clkEn(clkEn), .jtagClkEn(jtagClkEn),
        .watchdogResetOutN(wdRstN), .watchdogWakeIrqN(wdIrqN), .irq(irq)
    );

    wlp_core_model cpu (
        .mclk(mclk), .idleExec(idleExec), .exitPins(exitPins),
        .gpioA(gpioA)
    );

    task automatic complete_run();
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr   <= a;
        wrData <= d;
        wrEn   <= 1'b1;
        @(posedge mclk);
        wrEn   <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdReg(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge mclk);
        rdEn <= 1'b0;
        #1 rd = rdData;
    endtask

    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask

    // Both key writes back to back, strobe held across the pair
    task automatic keyClear();
        @(posedge mclk);
        addr   <= WLP_OFS_WDKEY;
        wrData <= 32'h55;
        wrEn   <= 1'b1;
        @(posedge mclk);
        wrData <= 32'hAA;
        @(posedge mclk);
        wrEn   <= 1'b0;
    endtask

    task automatic waitState(input wlp_state_t s);
        for (int n = 0; n < 500; n++) begin
            rdReg(WLP_OFS_STATE);
            if (rd === 32'(s))
                break;
        end
    endtask

    task automatic t_key();
        keyClear();
        rdReg(WLP_OFS_WDCOUNT);
        chk({2'b00, rd[31:2]}, 32'h0);
        // A foreign key value between the pair must spoil it
        wr(WLP_OFS_WDKEY, 32'h55);
        wr(WLP_OFS_WDKEY, 32'h12);
        wr(WLP_OFS_WDKEY, 32'hAA);
        rdReg(WLP_OFS_WDCOUNT);
        chk(32'(rd > 32'd6), 32'h1);
        rdReg(WLP_OFS_IRQSTAT);
        chk(32'(rd[WLP_IRQ_KEYER]), 32'h1);
    endtask

    task automatic t_overflow();
        int n;
        wr(WLP_OFS_IRQCLR, 32'h7);
        wr(WLP_OFS_IRQEN, 32'h1);
        for (n = 0; n < 400 && wdRstN !== 1'b0; n++) @(posedge mclk) #1;
        for (n = 0; n < 600 && wdRstN === 1'b0; n++) @(posedge mclk) #1;
        chk(32'(n), 32'(WLP_WATCHDOG_RESET_OUT_CYC));
        chk(32'(irq), 32'h1);
        wr(WLP_OFS_IRQEN, 32'h0);
        settle();
        chk(32'(irq), 32'h0);
        wr(WLP_OFS_IRQEN, 32'h1);
        settle();
        chk(32'(irq), 32'h1);
        wr(WLP_OFS_IRQCLR, 32'h1);
        settle();
        chk(32'(irq), 32'h0);
    endtask

    task automatic t_disable();
        wr(WLP_OFS_WDCTRL, 32'h1);
        keyClear();
        lowSeen = 1'b0;
        repeat (300) begin
            @(posedge mclk) #1;
            if (wdRstN !== 1'b1)
                lowSeen = 1'b1;
        end
        chk(32'(lowSeen), 32'h0);
        wr(WLP_OFS_WDCTRL, 32'h0);
    endtask

    task automatic t_standby();
        keyClear();
        pinsIn <= 32'hA5A5A5A5;
        wr(WLP_OFS_SLEEPCTL, 32'h1);
        cpu.doIdle();
        pinsIn <= 32'h0;
        settle();
        chk({clkEn.osc, clkEn.cpu, clkEn.sysOut}, 3'b100);
        chk(pinsOut, 32'hA5A5A5A5);
        rdReg(WLP_OFS_WDCOUNT);
        c1 = rd;
        rdReg(WLP_OFS_WDCOUNT);
        chk(rd - c1, 32'h2);
        // Mode field is ignored outside the idle instruction in RUN
        wr(WLP_OFS_SLEEPCTL, 32'h2);
        cpu.doIdle();
        rdReg(WLP_OFS_STATE);
        chk(rd, 32'(ST_STANDBY));
        cpu.lowExit(2, 2);
        repeat (8) @(posedge mclk);
        rdReg(WLP_OFS_STATE);
        chk(rd, 32'(ST_STANDBY));
        cpu.lowExit(2, 8);
        waitState(ST_RUN);
        chk(rd, 32'(ST_RUN));
        settle();
        chk(32'(clkEn), 32'hF);
        chk(pinsOut, 32'h0);
        rdReg(WLP_OFS_IRQSTAT);
        chk(32'(rd[WLP_IRQ_WAKE]), 32'h1);
    endtask

    task automatic t_wakepin();
        wr(WLP_OFS_WAKESEL, 32'h8);
        wr(WLP_OFS_SLEEPCTL, 32'h0D);
        cpu.doIdle();
        cpu.lowPin(4, 40);
        cpu.lowPin(3, 3);
        repeat (8) @(posedge mclk);
        rdReg(WLP_OFS_STATE);
        chk(rd, 32'(ST_STANDBY));
        cpu.lowPin(3, 16);
        waitState(ST_RUN);
        chk(rd, 32'(ST_RUN));
    endtask

    task automatic t_halt();
        keyClear();
        wr(WLP_OFS_SLEEPCTL, 32'h2);
        cpu.doIdle();
        settle();
        chk(32'(clkEn), 32'h0);
        rdReg(WLP_OFS_WDCOUNT);
        c1 = rd;
        lowSeen = 1'b0;
        repeat (300) begin
            @(posedge mclk) #1;
            if (wdRstN !== 1'b1 || wdIrqN !== 1'b1)
                lowSeen = 1'b1;
        end
        chk(32'(lowSeen), 32'h0);
        rdReg(WLP_OFS_WDCOUNT);
        chk(rd, c1);
        cpu.lowPin(3, 8);
        waitState(ST_RUN);
        chk(rd, 32'(ST_RUN));
    endtask

    task automatic t_idle();
        wr(WLP_OFS_SLEEPCTL, 32'h0);
        cpu.doIdle();
        settle();
        chk(32'(clkEn), 32'hF);
        rdReg(WLP_OFS_STATE);
        chk(rd, 32'(ST_IDLE));
        cpu.lowExit(0, 8);
        waitState(ST_RUN);
        chk(rd, 32'(ST_RUN));
        cpu.doIdle();
        cpu.lowExit(3, 2);
        rdReg(WLP_OFS_STATE);
        chk(rd, 32'(ST_RUN));
    endtask

    task automatic t_wdIrq();
        int n;
        wr(WLP_OFS_WDCTRL, 32'h6);
        keyClear();
        wr(WLP_OFS_SLEEPCTL, 32'h1);
        cpu.doIdle();
        rdReg(WLP_OFS_STATE);
        chk(rd, 32'(ST_STANDBY));
        waitState(ST_RUN);
        chk(rd, 32'(ST_RUN));
        chk(32'(wdRstN), 32'h1);
        for (n = 0; n < 600 && wdIrqN !== 1'b1; n++) @(posedge mclk) #1;
        wr(WLP_OFS_SLEEPCTL, 32'h0);
        keyClear();
        cpu.doIdle();
        waitState(ST_RUN);
        chk(rd, 32'(ST_RUN));
        chk(32'(wdIrqN), 32'h0);
        wr(WLP_OFS_WDCTRL, 32'h0);
    endtask

    initial begin
        #320000;
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge mclk);
        #1;
        chk(32'({jtagClkEn, wdRstN, wdIrqN, irq}), 32'h6);
        chk(32'(clkEn), 32'hF);
        @(posedge mclk) rstn <= 1'b1;
        settle();
        chk(32'(jtagClkEn), 32'h1);
        rdReg(8'h3C);
        chk(rd, 32'h0);
        t_key();
        t_overflow();
        t_disable();
        t_standby();
        t_wakepin();
        t_halt();
        t_idle();
        t_wdIrq();
        complete_run();
    end
endmodule
